//--- include/dbg_entry_pkg.sv
// Constants and types shared by the debug entry controller.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
package dbg_entry_pkg;

   localparam int unsigned CLK_PERIOD_NS    = 4;
   // Program counter offset in instructions seen on watchpoint entry (five words on)
   localparam int unsigned WPT_PC_AHEAD_INS = 5;
   localparam int unsigned INSTR_BYTES      = 4;
   localparam logic [7:0]  WPT_PC_REWIND    = 8'(WPT_PC_AHEAD_INS * INSTR_BYTES);
   localparam logic        SYNC_RESET_VAL   = 1'b0;
   localparam logic [1:0]  WPT_DELAY_DP     = 2'h2;
   localparam logic [1:0]  WPT_DELAY_OTHER  = 2'h1;

   typedef enum logic [1:0] {
      CAUSE_NONE,
      CAUSE_BREAKPOINT,
      CAUSE_WATCHPOINT,
      CAUSE_REQUEST
   } entry_cause_t;

endpackage

//--- rtl/debug_entry_control.sv
// Debug entry controller: decides when the core halts into debug state.
// Assumes the pipeline front end supplies per-stage valid and type strobes
// and obeys the issue-stall and state-change suppress outputs in the same cycle.
//
// What this block does
// (RQ1) External breakpoint asserted in the fetch cycle
// (RQ2) OR external and internal breakpoint conditions
// (RQ3) Breakpointed instruction executes without state change
// (RQ4) Latched breakpoint starts entry during its Execute
// (RQ5) Prefetch abort beats breakpoint
// (RQ6) Breakpoint beats software interrupt or undefined
// (RQ7) Interrupt beats breakpoint; instruction discarded, refetched
// (RQ8) Block interrupts in debug, status word untouched
// (RQ9) OR external and internal watchpoint; imprecise entry
// (RQ10) Next instruction always completes after watchpoint
// (RQ11) Single-cycle data op delays entry one cycle
// (RQ12) Following instruction suppressed, resumes there later
// (RQ13) Program counter five instructions ahead on watchpoint
// (RQ14) Aborting watchpointed access: abort entry, then debug
// (RQ15) Pending interrupt: exception entry first, then debug
// (RQ16) Synchronized debug request beats pending interrupt
// (RQ17) Request stops issue, waits for memory/write stages
// (RQ18) Request in monitor mode enters as halt
// (RQ19) Idle cycles on both memory interfaces in debug
// (RQ20) Ignore aborts and interrupts in debug
// (RQ21) Drive debug acknowledge while in debug
// (RQ22) System keeps reset stable during debug
// (RQ23) Debug enable low gates inputs, acknowledge low
// (RQ24) Two-stage synchronizer on external debug request
`timescale 1ns/100ps
module debug_entry_control
   import dbg_entry_pkg::*;
(
   input  wire logic                CLK_SYS_I,
   input  wire logic                SRST_I,
   input  wire logic                DEBUG_ENABLE_IN_I,
   input  wire logic                EXT_BREAKPOINT_IN_I,
   input  wire logic                INT_BREAKPOINT_I,
   input  wire logic                EXT_WATCHPOINT_IN_I,
   input  wire logic                INT_WATCHPOINT_I,
   input  wire logic                EXT_DEBUG_REQUEST_I,
   input  wire logic                INT_DEBUG_REQUEST_I,
   input  wire logic                MONITOR_MODE_I,
   input  wire logic                FETCH_VALID_I,
   input  wire logic                EXEC_VALID_I,
   input  wire logic                EXEC_PREFETCH_ABORT_I,
   input  wire logic                EXEC_SINGLE_CYCLE_DP_I,
   input  wire logic                DATA_ABORT_I,
   input  wire logic                NORMAL_INTERRUPT_N_I,
   input  wire logic                FAST_INTERRUPT_N_I,
   input  wire logic                EXC_ENTRY_DONE_I,
   input  wire logic                PIPE_DRAINED_I,
   input  wire logic                RESTART_I,
   output logic                     DEBUG_ACKNOWLEDGE_O,
   output logic                     ISSUE_STALL_O,
   output logic                     EXEC_SUPPRESS_O,
   output logic                     TAKE_IRQ_O,
   output logic                     TAKE_FIQ_O,
   output logic                     TAKE_PREFETCH_ABORT_O,
   output logic                     TAKE_DATA_ABORT_O,
   output logic                     MEM_IDLE_O,
   output logic [7:0]               PC_REWIND_O,
   output dbg_entry_pkg::entry_cause_t ENTRY_CAUSE_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Input gating and synchronisation
   logic bkpt_tag_reg;
   logic req_meta_reg;
   logic req_sync_reg;
   logic bkpt_any;
   logic wpt_any;
   logic req_any;
   logic irq_pending;
   logic fiq_pending;

   assign bkpt_any = (EXT_BREAKPOINT_IN_I & DEBUG_ENABLE_IN_I) | INT_BREAKPOINT_I; // [RQ2] [RQ23]
   assign wpt_any  = (EXT_WATCHPOINT_IN_I & DEBUG_ENABLE_IN_I) | INT_WATCHPOINT_I; // [RQ9] [RQ23]
   // Monitor mode makes no difference: request always halts
   assign req_any  = req_sync_reg | INT_DEBUG_REQUEST_I; // [RQ16] [RQ18]

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         req_meta_reg <= SYNC_RESET_VAL;
         req_sync_reg <= SYNC_RESET_VAL;
      end else begin
         req_meta_reg <= EXT_DEBUG_REQUEST_I & DEBUG_ENABLE_IN_I; // [RQ24] [RQ23]
         req_sync_reg <= req_meta_reg; // [RQ24]
      end
   end

   // Breakpoint is sampled with the fetch at cycle end and rides to Execute
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         bkpt_tag_reg <= 1'b0;
      end else if (FETCH_VALID_I) begin
         bkpt_tag_reg <= bkpt_any; // [RQ1] [RQ4]
      end else if (EXEC_VALID_I) begin
         bkpt_tag_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Entry state machine
   typedef enum logic [2:0] {
      ST_RUN,
      ST_WPT_WAIT,
      ST_EXC_THEN_DBG,
      ST_REQ_DRAIN,
      ST_DEBUG
   } state_t;

   state_t       state_reg;
   state_t       state_next;
   logic [1:0]   wpt_cnt_reg;
   entry_cause_t cause_reg;
   logic         in_debug;
   logic         bkpt_hit;
   logic         int_take;

   assign in_debug    = (state_reg == ST_DEBUG);
   assign irq_pending = ~NORMAL_INTERRUPT_N_I & ~in_debug; // [RQ8] [RQ20]
   assign fiq_pending = ~FAST_INTERRUPT_N_I & ~in_debug;   // [RQ8] [RQ20]
   // Breakpoint only counts if no prefetch abort and no interrupt at boundary
   assign int_take    = (irq_pending | fiq_pending) & ~req_any & (state_reg == ST_RUN); // [RQ16]
   assign bkpt_hit    = EXEC_VALID_I & bkpt_tag_reg & ~EXEC_PREFETCH_ABORT_I & ~int_take
                        & (state_reg == ST_RUN); // [RQ5] [RQ6] [RQ7]

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (req_any) begin
               state_next = ST_REQ_DRAIN; // [RQ16] [RQ17]
            end else if (bkpt_hit) begin
               state_next = ST_DEBUG; // [RQ4]
            end else if (wpt_any && (DATA_ABORT_I || irq_pending || fiq_pending)) begin
               state_next = ST_EXC_THEN_DBG; // [RQ14] [RQ15]
            end else if (wpt_any) begin
               state_next = ST_WPT_WAIT; // [RQ10]
            end
         end
         ST_WPT_WAIT: begin
            if (wpt_cnt_reg == 2'h1) begin
               state_next = ST_DEBUG; // [RQ11]
            end
         end
         ST_EXC_THEN_DBG: begin
            if (EXC_ENTRY_DONE_I) begin
               state_next = ST_DEBUG; // [RQ14] [RQ15]
            end
         end
         ST_REQ_DRAIN: begin
            if (PIPE_DRAINED_I) begin
               state_next = ST_DEBUG; // [RQ17]
            end
         end
         ST_DEBUG: begin
            if (RESTART_I) begin
               state_next = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         state_reg <= ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Counts the completing instruction after a watchpoint
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         wpt_cnt_reg <= 2'h0;
      end else if (state_reg == ST_RUN && state_next == ST_WPT_WAIT) begin
         wpt_cnt_reg <= EXEC_SINGLE_CYCLE_DP_I ? WPT_DELAY_DP : WPT_DELAY_OTHER; // [RQ11]
      end else if (state_reg == ST_WPT_WAIT && wpt_cnt_reg != 2'h0) begin
         wpt_cnt_reg <= wpt_cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         cause_reg <= CAUSE_NONE;
      end else if (state_reg == ST_RUN) begin
         if (req_any) begin
            cause_reg <= CAUSE_REQUEST;
         end else if (bkpt_hit) begin
            cause_reg <= CAUSE_BREAKPOINT;
         end else if (wpt_any) begin
            cause_reg <= CAUSE_WATCHPOINT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         DEBUG_ACKNOWLEDGE_O <= 1'b0;
         MEM_IDLE_O          <= 1'b0;
         PC_REWIND_O         <= 8'h00;
         ENTRY_CAUSE_O       <= CAUSE_NONE;
      end else begin
         DEBUG_ACKNOWLEDGE_O <= (state_next == ST_DEBUG) & DEBUG_ENABLE_IN_I; // [RQ21] [RQ23]
         MEM_IDLE_O          <= (state_next == ST_DEBUG); // [RQ19]
         PC_REWIND_O         <= (cause_reg == CAUSE_WATCHPOINT) ? WPT_PC_REWIND : 8'h00; // [RQ13]
         ENTRY_CAUSE_O       <= cause_reg;
      end
   end

   // Suppress state change for breakpointed op and op after completing one
   assign EXEC_SUPPRESS_O = bkpt_hit | in_debug
                            | (state_reg == ST_WPT_WAIT && wpt_cnt_reg == 2'h1); // [RQ3] [RQ12]
   assign ISSUE_STALL_O   = (state_reg == ST_REQ_DRAIN) | in_debug; // [RQ17]
   assign TAKE_FIQ_O      = int_take & fiq_pending; // [RQ7]
   assign TAKE_IRQ_O      = int_take & irq_pending & ~fiq_pending; // [RQ7]
   assign TAKE_PREFETCH_ABORT_O = EXEC_VALID_I & EXEC_PREFETCH_ABORT_I & ~in_debug; // [RQ5]
   assign TAKE_DATA_ABORT_O     = DATA_ABORT_I & ~in_debug; // [RQ14] [RQ20]

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_req_seen;
      req_any && state_reg == ST_RUN;
   endsequence

   sequence s_wpt_dp_start;
      state_reg == ST_RUN && state_next == ST_WPT_WAIT && EXEC_SINGLE_CYCLE_DP_I;
   endsequence

   sequence s_dbg_entered;
      !in_debug ##1 in_debug;
   endsequence

   // A request in the same cycle outranks the breakpoint
   a_bkpt_enters_debug: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ4]
      (bkpt_hit && !req_any) |=> in_debug)
      else $error("breakpoint did not enter debug");

   a_pabt_over_bkpt: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ5]
      EXEC_PREFETCH_ABORT_I |-> !bkpt_hit)
      else $error("breakpoint taken over prefetch abort");

   a_irq_over_bkpt: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ7]
      int_take |-> !bkpt_hit && (TAKE_IRQ_O || TAKE_FIQ_O))
      else $error("interrupt lost against breakpoint");

   a_no_irq_in_dbg: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ8]
      in_debug |-> !TAKE_IRQ_O && !TAKE_FIQ_O && !TAKE_DATA_ABORT_O)
      else $error("interrupt or abort taken in debug");

   a_wpt_dp_delay: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ11]
      s_wpt_dp_start
      |=> !in_debug ##1 !in_debug ##1 in_debug)
      else $error("watchpoint delay wrong");

   a_wpt_pc_rewind: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ13]
      (in_debug && cause_reg == CAUSE_WATCHPOINT) |=> PC_REWIND_O == 8'h14)
      else $error("watchpoint rewind not 20");

   a_req_stalls: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ17]
      s_req_seen |=> ISSUE_STALL_O)
      else $error("issue not stalled after request");

   a_req_sync_lat: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ24]
      $rose(req_sync_reg) |-> $past(EXT_DEBUG_REQUEST_I, 2))
      else $error("request bypassed synchronizer");

   a_ack_follows: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ21]
      (in_debug && DEBUG_ENABLE_IN_I && $past(DEBUG_ENABLE_IN_I)) |-> DEBUG_ACKNOWLEDGE_O)
      else $error("acknowledge missing in debug");

   a_disable_ack: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ23]
      !$past(DEBUG_ENABLE_IN_I) |-> !DEBUG_ACKNOWLEDGE_O)
      else $error("acknowledge high while disabled");

   a_mem_idle: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ19]
      (in_debug && $past(in_debug)) |-> MEM_IDLE_O)
      else $error("memory not idle in debug");

   a_bkpt_suppress: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ3]
      (EXEC_VALID_I && bkpt_tag_reg && !EXEC_PREFETCH_ABORT_I && state_reg == ST_RUN
       && NORMAL_INTERRUPT_N_I && FAST_INTERRUPT_N_I) |-> EXEC_SUPPRESS_O)
      else $error("breakpointed instruction not suppressed");

   a_bkpt_tag_fetch: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ1] [RQ2]
      (FETCH_VALID_I && ((EXT_BREAKPOINT_IN_I && DEBUG_ENABLE_IN_I) || INT_BREAKPOINT_I))
      |=> bkpt_tag_reg)
      else $error("breakpoint not latched with fetch");

   a_bkpt_gated: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ23]
      (FETCH_VALID_I && !DEBUG_ENABLE_IN_I && !INT_BREAKPOINT_I) |=> !bkpt_tag_reg)
      else $error("external breakpoint passed while disabled");

   a_pabt_taken: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ5]
      (EXEC_VALID_I && EXEC_PREFETCH_ABORT_I && state_reg == ST_RUN)
      |-> TAKE_PREFETCH_ABORT_O ##1 !in_debug)
      else $error("prefetch abort lost");

   a_irq_discards: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ7]
      (EXEC_VALID_I && bkpt_tag_reg && state_reg == ST_RUN && !req_any
       && !(NORMAL_INTERRUPT_N_I && FAST_INTERRUPT_N_I))
      |-> (TAKE_IRQ_O || TAKE_FIQ_O) ##1 !in_debug)
      else $error("breakpoint kept over interrupt");

   a_entry_idle: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ19]
      s_dbg_entered |-> MEM_IDLE_O && ISSUE_STALL_O)
      else $error("memory not idle on debug entry");

   a_wpt_gate: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ9]
      (state_reg == ST_RUN && !req_any && !bkpt_hit && EXT_WATCHPOINT_IN_I
       && DEBUG_ENABLE_IN_I) |=> state_reg != ST_RUN)
      else $error("external watchpoint ignored");

   a_wpt_off: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ23]
      (state_reg == ST_RUN && !req_any && !bkpt_hit && !INT_WATCHPOINT_I
       && !DEBUG_ENABLE_IN_I) |=> state_reg == ST_RUN)
      else $error("external watchpoint passed while disabled");

   a_wpt_other_delay: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ10]
      (state_reg == ST_RUN && state_next == ST_WPT_WAIT && !EXEC_SINGLE_CYCLE_DP_I)
      |=> !in_debug ##1 in_debug)
      else $error("watchpoint entry timing wrong");

   a_wpt_dp_supp: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ12]
      s_wpt_dp_start |=> !EXEC_SUPPRESS_O ##1 EXEC_SUPPRESS_O)
      else $error("wrong instruction suppressed after watchpoint");

   a_exc_wait: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ15]
      (state_reg == ST_EXC_THEN_DBG && !EXC_ENTRY_DONE_I) |=> !in_debug)
      else $error("debug entered before exception entry");

   a_exc_done: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ14]
      (state_reg == ST_EXC_THEN_DBG && EXC_ENTRY_DONE_I) |=> in_debug)
      else $error("debug not entered after exception entry");

   a_abt_with_wpt: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ14]
      (state_reg == ST_RUN && wpt_any && DATA_ABORT_I && !req_any && !bkpt_hit)
      |-> TAKE_DATA_ABORT_O ##1 state_reg == ST_EXC_THEN_DBG)
      else $error("aborting watchpoint mishandled");

   a_req_over_irq: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ16]
      s_req_seen |-> !TAKE_IRQ_O && !TAKE_FIQ_O)
      else $error("interrupt taken over debug request");

   a_drain_wait: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ17]
      (state_reg == ST_REQ_DRAIN && !PIPE_DRAINED_I)
      |=> ISSUE_STALL_O && !DEBUG_ACKNOWLEDGE_O)
      else $error("debug entered before pipeline drained");

   a_mon_req: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ18]
      (req_any && MONITOR_MODE_I && state_reg == ST_RUN) |=> state_reg == ST_REQ_DRAIN)
      else $error("request in monitor mode not halting");

   a_restart_exit: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ21]
      (in_debug && RESTART_I) |=> !DEBUG_ACKNOWLEDGE_O && !MEM_IDLE_O)
      else $error("acknowledge held after restart");

endmodule

//--- dv/ext_debug_logic.sv
// Model of the external comparators and debug request source.
// Assumes the bench arms each source after a falling clock edge.
`timescale 1ns/100ps
module ext_debug_logic (
   input  wire logic fetch_valid_i,
   input  wire logic bkpt_arm_i,
   input  wire logic wpt_arm_i,
   input  wire logic req_arm_i,
   output logic      ext_bkpt_o,
   output logic      ext_wpt_o,
   output logic      ext_req_o
);
   // Breakpoint raised within the fetch cycle itself
   assign ext_bkpt_o = bkpt_arm_i & fetch_valid_i;
   assign ext_wpt_o  = wpt_arm_i;
   assign ext_req_o  = req_arm_i;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the debug entry controller.
// Assumes the package, the design and ext_debug_logic are compiled first.
`timescale 1ns/100ps
module testbench;
   import dbg_entry_pkg::*;
   logic         clk, srst, en, bki, wpi, rqi, mon, fv, ev, pab, dp, dab, irqn, fiqn;
   logic         exd, drn, rs, abk, awp, arq, ebk, ewp, erq, ack, stall, sup;
   logic         tirq, tfiq, tpab, tdab, idle;
   logic [7:0]   rew;
   entry_cause_t cause;
   int           err_total, check_count, seed, k, r;
   int           lat[2];

   ext_debug_logic partner (.fetch_valid_i(fv), .bkpt_arm_i(abk), .wpt_arm_i(awp),
      .req_arm_i(arq), .ext_bkpt_o(ebk), .ext_wpt_o(ewp), .ext_req_o(erq));
   debug_entry_control uut (.CLK_SYS_I(clk), .SRST_I(srst), .DEBUG_ENABLE_IN_I(en),
      .EXT_BREAKPOINT_IN_I(ebk), .INT_BREAKPOINT_I(bki), .EXT_WATCHPOINT_IN_I(ewp),
      .INT_WATCHPOINT_I(wpi), .EXT_DEBUG_REQUEST_I(erq), .INT_DEBUG_REQUEST_I(rqi),
      .MONITOR_MODE_I(mon), .FETCH_VALID_I(fv), .EXEC_VALID_I(ev),
      .EXEC_PREFETCH_ABORT_I(pab), .EXEC_SINGLE_CYCLE_DP_I(dp), .DATA_ABORT_I(dab),
      .NORMAL_INTERRUPT_N_I(irqn), .FAST_INTERRUPT_N_I(fiqn), .EXC_ENTRY_DONE_I(exd),
      .PIPE_DRAINED_I(drn), .RESTART_I(rs), .DEBUG_ACKNOWLEDGE_O(ack),
      .ISSUE_STALL_O(stall), .EXEC_SUPPRESS_O(sup), .TAKE_IRQ_O(tirq), .TAKE_FIQ_O(tfiq),
      .TAKE_PREFETCH_ABORT_O(tpab), .TAKE_DATA_ABORT_O(tdab), .MEM_IDLE_O(idle),
      .PC_REWIND_O(rew), .ENTRY_CAUSE_O(cause));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_ack(input int lim);
      for (k = 0; k < lim && ack !== 1'b1; k++) cyc(1);
      check("ack_wait", 8'(ack), 8'h01);
      if (ack !== 1'b1) test_done();
   endtask
   // Interrupts and a data abort raised in debug must be ignored, then leave
   task automatic in_debug;
      {irqn, fiqn, dab} = 3'b001;
      #1;
      check("take_irq", 8'(tirq), 8'h00);
      check("take_fiq", 8'(tfiq), 8'h00);
      check("take_dabt", 8'(tdab), 8'h00);
      cyc(2);
      check("ack", 8'(ack), 8'h01);
      {irqn, fiqn, dab, rs} = 4'b1101;
      cyc(1);
      rs = 1'b0;
      cyc(1);
      check("ack", 8'(ack), 8'h00);
   endtask
   task automatic bkpt(input logic ext, input logic irq, input logic pa);
      {fv, abk, bki} = {1'b1, ext, !ext};
      cyc(1);
      {fv, abk, bki, ev, pab, irqn} = {4'b0001, pa, !irq};
      #1;
      check("take_irq", 8'(tirq), 8'(irq));
      check("take_pabt", 8'(tpab), 8'(pa));
      if (!irq && !pa) check("suppress", 8'(sup), 8'h01);
      cyc(1);
      {ev, pab, irqn} = 3'b001;
      check("ack", 8'(ack), 8'(!irq && !pa));
      if (!irq && !pa) begin
         check("idle", 8'(idle), 8'h01);
         check("stall", 8'(stall), 8'h01);
         // The cause output is registered one edge behind entry
         cyc(1);
         check("cause", 8'(cause), 8'(CAUSE_BREAKPOINT));
         in_debug();
      end else cyc(2);
   endtask
   task automatic wpt(input logic ext, input logic d, input int x);
      {awp, wpi, dp, ev, dab, irqn} = {ext, !ext, d, 1'b1, x == 1, x != 2};
      #1;
      if (x == 1) check("take_dabt", 8'(tdab), 8'h01);
      if (x == 2) check("take_irq", 8'(tirq), 8'h01);
      cyc(1);
      {awp, wpi, dab, irqn} = 4'b0001;
      if (x == 0 && d) check("suppress", 8'(sup), 8'h00);
      if (x != 0) begin
         cyc(4);
         check("ack", 8'(ack), 8'h00);
         exd = 1'b1;
         cyc(1);
         exd = 1'b0;
      end
      wait_ack(6);
      if (x == 0) lat[d] = k;
      {ev, dp} = 2'b00;
      check("rewind", rew, WPT_PC_REWIND);
      check("cause", 8'(cause), 8'(CAUSE_WATCHPOINT));
      in_debug();
   endtask
   task automatic req(input logic ext, input logic m);
      {mon, arq, rqi, ev, drn} = {m, ext, !ext, 2'b10};
      cyc(1);
      check("ack", 8'(ack), 8'h00);
      check("stall", 8'(stall), 8'(!ext));
      cyc(2);
      irqn = 1'b0;
      #1;
      check("take_irq", 8'(tirq), 8'h00);
      check("stall", 8'(stall), 8'h01);
      cyc(3);
      check("ack", 8'(ack), 8'h00);
      {drn, ev, irqn} = 3'b101;
      wait_ack(3);
      check("cause", 8'(cause), 8'(CAUSE_REQUEST));
      {arq, rqi, drn} = 3'b000;
      in_debug();
   endtask
   task automatic dis;
      {en, fv, abk, awp, arq, ev, drn} = 7'h3F;
      cyc(1);
      {fv, abk, awp, rqi} = 4'h1;
      check("suppress", 8'(sup), 8'h00);
      cyc(5);
      check("idle", 8'(idle), 8'h01);
      check("ack", 8'(ack), 8'h00);
      {arq, rqi, ev, drn, rs} = 5'h01;
      cyc(1);
      rs = 1'b0;
      cyc(1);
      en = 1'b1;
      cyc(1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h103EF388;
      {srst, en, bki, wpi, rqi, mon, fv, ev, pab, dp, dab, exd, drn, rs} = 14'h3000;
      {irqn, fiqn, abk, awp, arq} = 5'h18;
      // Reset stays put while any debug session runs
      cyc(20);
      srst = 1'b0;
      cyc(1);
      check("ack", 8'(ack), 8'h00);
      check("rewind", rew, 8'h00);
      check("cause", 8'(cause), 8'(CAUSE_NONE));
      bkpt(1, 0, 0);
      bkpt(0, 0, 0);
      bkpt(1, 1, 0);
      bkpt(0, 0, 1);
      for (int i = 0; i < 4; i++) wpt(i[0], i[1], 0);
      check("wpt_dp_delay", 8'(lat[1] - lat[0]), 8'h01);
      wpt(1, 0, 1);
      wpt(0, 1, 2);
      req(1, 0);
      req(0, 1);
      req(1, 1);
      dis();
      repeat (24) begin
         r = $random(seed);
         case (r[1:0])
            2'h0: bkpt(r[2], r[3], r[4] & !r[3]);
            2'h1: wpt(r[2], r[3], 0);
            2'h2: req(r[2], r[3]);
            default: dis();
         endcase
         cyc(r[6:5]);
      end
      test_done();
   end
endmodule
